/* File: pdd_pkg.sv */
package pdd_pkg;

    // register and bus geometry
    localparam int PIN_W = 32;
    localparam int HALF_W = 16;
    localparam int APB_AW = 12;
    localparam int IDX_W = 10;

    // printed offsets kept as register indices; byte address is index * 4
    localparam logic [31:0] UPPER_DATA_IDX = 32'hffff1230;
    localparam logic [31:0] LOWER_DATA_IDX = 32'hffff1232;
    localparam logic [31:0] UPPER_DIR_IDX = 32'hffff1234;
    localparam logic [31:0] LOWER_DIR_IDX = 32'hffff1236;
    localparam logic [31:0] UPPER_ALT_IDX = 32'hffff1238;
    localparam logic [31:0] LOWER_ALT_IDX = 32'hffff123a;
    localparam logic [31:0] UPPER_LVL_IDX = 32'hffff123c;
    localparam logic [31:0] LOWER_LVL_IDX = 32'hffff123e;

    // field positions inside a bus word
    localparam int HALF_LO_LSB = 0;
    localparam int HALF_HI_LSB = 16;

    // reset values
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [15:0] DIR_RST = 16'h0000;
    localparam logic [15:0] ALT_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // bus phase of the slave
    typedef enum logic [1:0] {
        PDD_IDLE = 2'b00,
        PDD_WAIT = 2'b01,
        PDD_DONE = 2'b10
    } pdd_phase_e;

    // true when the word index of the bus address selects a register
    function automatic logic pdd_hit(input logic [IDX_W-1:0] word_idx,
                                     input logic [31:0] reg_idx);
        pdd_hit = (word_idx == reg_idx[IDX_W-1:0]);
    endfunction : pdd_hit

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] pdd_merge(input logic [15:0] old_val,
                                              input logic [15:0] new_val,
                                              input logic [1:0] lanes);
        logic [15:0] res;
        res = old_val;
        if (lanes[0]) begin
            res[7:0] = new_val[7:0];
        end
        if (lanes[1]) begin
            res[15:8] = new_val[15:8];
        end
        pdd_merge = res;
    endfunction : pdd_merge

endpackage : pdd_pkg

/* File: pdd_pin_view.sv */
`timescale 1ns/10ps
module pdd_pin_view #(
    parameter int WIDTH = 32
) (
    // per-pin configuration and state
    input wire logic [WIDTH-1:0] data,
    input wire logic [WIDTH-1:0] dir,
    input wire logic [WIDTH-1:0] alt,
    input wire logic [WIDTH-1:0] pin_in,
    // value a read returns
    output logic [WIDTH-1:0] view
);

    // output pins show storage; general inputs show the pin; others read 0
    always_comb begin
        view = (dir & data) | (~dir & ~alt & pin_in);
    end

endmodule : pdd_pin_view

/* File: pdd_port.sv */
// Local design decision: register access over APB.
`timescale 1ns/10ps
module pdd_port
    import pdd_pkg::*;
(
    // apb clock and power-on reset
    input wire logic pclk,
    input wire logic presetn,
    // watchdog reset, synchronous, active high
    input wire logic watchdog_timer_reset,
    // apb request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pdd_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // apb answer
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // port pins
    input wire logic [pdd_pkg::PIN_W-1:0] pin_in,
    output logic [pdd_pkg::PIN_W-1:0] pin_out,
    output logic [pdd_pkg::PIN_W-1:0] pin_oe
);
    import pdd_pkg::*;

    typedef struct packed {
        pdd_phase_e phase;
        logic [HALF_W-1:0] upper_data;
        logic [HALF_W-1:0] lower_data;
        logic [HALF_W-1:0] upper_dir;
        logic [HALF_W-1:0] lower_dir;
        logic [HALF_W-1:0] upper_alt;
        logic [HALF_W-1:0] lower_alt;
        logic [PIN_W-1:0] oe;
        logic [31:0] rdata;
        logic err;
        logic ready;
    } pdd_state_s;

    localparam pdd_state_s STATE_RST = '{
        phase: PDD_IDLE,
        upper_data: DATA_RST,
        lower_data: DATA_RST,
        upper_dir: DIR_RST,
        lower_dir: DIR_RST,
        upper_alt: ALT_RST,
        lower_alt: ALT_RST,
        oe: {PIN_W{1'b0}},
        rdata: RDATA_RST,
        err: 1'b0,
        ready: 1'b0
    };

    pdd_state_s state_reg;
    pdd_state_s state_next;

    logic [PIN_W-1:0] data_all;
    logic [PIN_W-1:0] dir_all;
    logic [PIN_W-1:0] alt_all;
    logic [PIN_W-1:0] view_all;

    // pin numbering: upper register on pins 31..16, lower on 15..0
    assign data_all = {state_reg.upper_data, state_reg.lower_data};
    assign dir_all = {state_reg.upper_dir, state_reg.lower_dir};
    assign alt_all = {state_reg.upper_alt, state_reg.lower_alt};

    pdd_pin_view #(
        .WIDTH(PIN_W)
    ) u_view (
        .data(data_all),
        .dir(dir_all),
        .alt(alt_all),
        .pin_in(pin_in),
        .view(view_all)
    );

    // address decode
    logic [IDX_W-1:0] word_idx;
    logic hit_upper_data;
    logic hit_lower_data;
    logic hit_upper_dir;
    logic hit_lower_dir;
    logic hit_upper_alt;
    logic hit_lower_alt;
    logic hit_upper_lvl;
    logic hit_lower_lvl;
    logic mapped;

    assign word_idx = paddr[APB_AW-1:2];
    assign hit_upper_data = pdd_hit(word_idx, UPPER_DATA_IDX);
    assign hit_lower_data = pdd_hit(word_idx, LOWER_DATA_IDX);
    assign hit_upper_dir = pdd_hit(word_idx, UPPER_DIR_IDX);
    assign hit_lower_dir = pdd_hit(word_idx, LOWER_DIR_IDX);
    assign hit_upper_alt = pdd_hit(word_idx, UPPER_ALT_IDX);
    assign hit_lower_alt = pdd_hit(word_idx, LOWER_ALT_IDX);
    assign hit_upper_lvl = pdd_hit(word_idx, UPPER_LVL_IDX);
    assign hit_lower_lvl = pdd_hit(word_idx, LOWER_LVL_IDX);
    assign mapped = hit_upper_data | hit_lower_data | hit_upper_dir
        | hit_lower_dir | hit_upper_alt | hit_lower_alt
        | hit_upper_lvl | hit_lower_lvl;

    // read value for the addressed word
    logic [31:0] read_word;
    logic [HALF_W-1:0] wr_lo;
    logic [HALF_W-1:0] wr_hi;

    assign wr_lo = pwdata[HALF_LO_LSB +: HALF_W];
    assign wr_hi = pwdata[HALF_HI_LSB +: HALF_W];

    always_comb begin
        read_word = 32'h0000_0000;
        if (hit_upper_data) begin
            // low half upper register, high half lower register
            read_word[HALF_LO_LSB +: HALF_W] = view_all[31:16];
            read_word[HALF_HI_LSB +: HALF_W] = view_all[15:0];
        end else if (hit_lower_data) begin
            read_word[HALF_LO_LSB +: HALF_W] = view_all[15:0];
        end else if (hit_upper_dir) begin
            read_word[HALF_LO_LSB +: HALF_W] = state_reg.upper_dir;
        end else if (hit_lower_dir) begin
            read_word[HALF_LO_LSB +: HALF_W] = state_reg.lower_dir;
        end else if (hit_upper_alt) begin
            read_word[HALF_LO_LSB +: HALF_W] = state_reg.upper_alt;
        end else if (hit_lower_alt) begin
            read_word[HALF_LO_LSB +: HALF_W] = state_reg.lower_alt;
        end else if (hit_upper_lvl) begin
            read_word[HALF_LO_LSB +: HALF_W] = pin_in[31:16];
        end else if (hit_lower_lvl) begin
            read_word[HALF_LO_LSB +: HALF_W] = pin_in[15:0];
        end
    end

    // next state
    logic do_write;

    always_comb begin
        state_next = state_reg;
        do_write = 1'b0;
        case (state_reg.phase)
            PDD_IDLE: begin
                if (psel && !penable) begin
                    // answer is prepared in the setup cycle
                    state_next.rdata = pwrite ? RDATA_RST : read_word;
                    state_next.err = !mapped;
                    state_next.phase = PDD_WAIT;
                end
            end
            PDD_WAIT: begin
                if (psel && penable) begin
                    do_write = pwrite && mapped;
                    // answer stands only while pready is high
                    state_next.rdata = RDATA_RST;
                    state_next.err = 1'b0;
                    state_next.phase = PDD_DONE;
                end else if (!psel) begin
                    state_next.rdata = RDATA_RST;
                    state_next.err = 1'b0;
                    state_next.phase = PDD_IDLE;
                end
            end
            PDD_DONE: begin
                state_next.rdata = RDATA_RST;
                state_next.err = 1'b0;
                state_next.phase = PDD_IDLE;
                if (psel && !penable) begin
                    state_next.rdata = pwrite ? RDATA_RST : read_word;
                    state_next.err = !mapped;
                    state_next.phase = PDD_WAIT;
                end
            end
            default: begin
                state_next.phase = PDD_IDLE;
            end
        endcase

        if (do_write) begin
            // storage is written whatever the pin function
            if (hit_upper_data) begin
                state_next.upper_data = pdd_merge(state_reg.upper_data,
                    wr_lo, pstrb[1:0]);
                state_next.lower_data = pdd_merge(state_reg.lower_data,
                    wr_hi, pstrb[3:2]);
            end
            if (hit_lower_data) begin
                state_next.lower_data = pdd_merge(state_reg.lower_data,
                    wr_lo, pstrb[1:0]);
            end
            if (hit_upper_dir) begin
                state_next.upper_dir = pdd_merge(state_reg.upper_dir,
                    wr_lo, pstrb[1:0]);
            end
            if (hit_lower_dir) begin
                state_next.lower_dir = pdd_merge(state_reg.lower_dir,
                    wr_lo, pstrb[1:0]);
            end
            if (hit_upper_alt) begin
                state_next.upper_alt = pdd_merge(state_reg.upper_alt,
                    wr_lo, pstrb[1:0]);
            end
            if (hit_lower_alt) begin
                state_next.lower_alt = pdd_merge(state_reg.lower_alt,
                    wr_lo, pstrb[1:0]);
            end
        end

        // watchdog reset clears configuration, never the data
        if (watchdog_timer_reset) begin
            state_next.upper_dir = DIR_RST;
            state_next.lower_dir = DIR_RST;
            state_next.upper_alt = ALT_RST;
            state_next.lower_alt = ALT_RST;
            state_next.phase = PDD_IDLE;
            state_next.rdata = RDATA_RST;
            state_next.err = 1'b0;
        end

        // drive only pins that are output and general purpose
        state_next.oe = {state_next.upper_dir, state_next.lower_dir}
            & ~{state_next.upper_alt, state_next.lower_alt};

        // ready kept in a flop so the bus answer is glitch free
        state_next.ready = (state_next.phase == PDD_WAIT);
    end

    // presetn is the power-on reset; nothing else clears the data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs
    assign prdata = state_reg.rdata;
    assign pready = state_reg.ready;
    assign pslverr = state_reg.err;
    assign pin_out = data_all;
    assign pin_oe = state_reg.oe;

endmodule : pdd_port

/* File: pdd_port_assertions.sv */
`timescale 1ns/10ps
module pdd_port_assertions
    import pdd_pkg::*;
(
    // clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic watchdog_timer_reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pdd_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic [pdd_pkg::PIN_W-1:0] pin_in,
    input wire logic [pdd_pkg::PIN_W-1:0] pin_out,
    input wire logic [pdd_pkg::PIN_W-1:0] pin_oe
);
    localparam logic [11:0] UP_A = {UPPER_DATA_IDX[9:0], 2'b00};
    localparam logic [11:0] LO_A = {LOWER_DATA_IDX[9:0], 2'b00};
    logic done;
    logic rd;
    assign done = psel && penable && pready && pwrite;
    assign rd = pready && !pwrite && !pslverr;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_RDY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_RDY_SETUP: assert property (psel && !penable |=> pready)
        else $error("no answer after setup cycle");
    AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer without ready or with data");
    AST_OUT_WRITE: assert property ($changed(pin_out) |-> $past(done))
        else $error("pin level changed without a write");
    AST_WATCHDOG_KEEP: assert property (
        watchdog_timer_reset && !done |=> $stable(pin_out))
        else $error("watchdog reset altered data");
    AST_WATCHDOG_OE: assert property (
        watchdog_timer_reset |=> pin_oe == 32'h0)
        else $error("drive kept after watchdog reset");
    AST_OE_CAUSE: assert property (
        $changed(pin_oe) |-> $past(done) || $past(watchdog_timer_reset))
        else $error("drive enable changed on its own");
    AST_RD_UP: assert property (
        rd && paddr == UP_A
        |-> ((prdata[15:0] ^ pin_out[31:16]) & pin_oe[31:16]) == 16'h0)
        else $error("upper read of driven pin not stored value");
    AST_RD_LO: assert property (
        rd && paddr == LO_A
        |-> ((prdata[15:0] ^ pin_out[15:0]) & pin_oe[15:0]) == 16'h0)
        else $error("lower read of driven pin not stored value");
    AST_LANE_KEEP: assert property (
        done && paddr == LO_A && !pstrb[0]
        |=> pin_out[7:0] == $past(pin_out[7:0]))
        else $error("unselected byte lane was written");
    AST_LO_WRITE: assert property (
        done && paddr == LO_A && pstrb[1:0] == 2'b11
        |=> pin_out[15:0] == $past(pwdata[15:0]))
        else $error("lower data write not on pins");
    cover property (done && paddr == UP_A);
    cover property (pslverr);
    cover property (watchdog_timer_reset && pin_out != 32'h0);
endmodule : pdd_port_assertions

bind pdd_port pdd_port_assertions u_pdd_port_assertions (.pclk(pclk),
    .presetn(presetn), .watchdog_timer_reset(watchdog_timer_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

/* File: pdd_pins.sv */
`timescale 1ns/10ps
module pdd_pins
    import pdd_pkg::*;
(
    // port drive and board level
    input wire logic [pdd_pkg::PIN_W-1:0] pin_out,
    input wire logic [pdd_pkg::PIN_W-1:0] pin_oe,
    input wire logic [pdd_pkg::PIN_W-1:0] ext_level,
    // resolved wire
    output logic [pdd_pkg::PIN_W-1:0] pin_in
);
    // driven pins show the port, the rest the board
    assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : pdd_pins

/* File: port_d_data_registers_bench.sv */
`timescale 1ns/10ps
module port_d_data_registers_bench;
    import pdd_pkg::*;
    localparam logic [11:0] UP_A = {UPPER_DATA_IDX[9:0], 2'b00};
    localparam logic [11:0] LO_A = {LOWER_DATA_IDX[9:0], 2'b00};
    localparam logic [11:0] LD_A = {LOWER_DIR_IDX[9:0], 2'b00};
    localparam logic [11:0] UD_A = {UPPER_DIR_IDX[9:0], 2'b00};
    localparam logic [11:0] LA_A = {LOWER_ALT_IDX[9:0], 2'b00};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic watchdog_rst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] ext = 32'h0;
    logic [31:0] prdata, rd, pin_in, pin_out, pin_oe, d;
    logic pready, pslverr, er;
    logic [15:0] up_m, lo_m;
    int miscompares = 0;
    int num_checks = 0;
    always #2.5 pclk = ~pclk;
    pdd_port u_pdd_port (.pclk(pclk), .presetn(presetn),
        .watchdog_timer_reset(watchdog_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    pdd_pins u_pdd_pins (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_level(ext), .pin_in(pin_in));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    task apb(input logic w, input logic [11:0] a, input logic [31:0] v,
             input logic [3:0] s);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            miscompares++;
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    function automatic logic [15:0] merge(input logic [15:0] o,
                                          input logic [15:0] n,
                                          input logic [1:0] l);
        merge = {l[1] ? n[15:8] : o[15:8], l[0] ? n[7:0] : o[7:0]};
    endfunction : merge
    task lo_rd(input logic [15:0] exp);
        apb(1'b0, LO_A, 32'h0, 4'h0);
        chk({16'h0, rd[15:0]}, {16'h0, exp});
    endtask : lo_rd
    initial begin
        void'($urandom(32'hddd6));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        up_m = 16'h0;
        lo_m = 16'h0;
        apb(1'b0, UP_A, 32'h0, 4'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, UD_A, 32'hffff, 4'hf);
        apb(1'b1, LD_A, 32'hffff, 4'hf);
        for (int i = 0; i < 40; i++) begin
            d = $urandom;
            pstrb <= 4'($urandom);
            @(posedge pclk);
            ext <= ~pin_out;
            apb(1'b1, UP_A, d, pstrb);
            up_m = merge(up_m, d[15:0], pstrb[1:0]);
            lo_m = merge(lo_m, d[31:16], pstrb[3:2]);
            chk(pin_out, {up_m, lo_m});
            apb(1'b0, UP_A, 32'h0, 4'h0);
            chk(rd, {lo_m, up_m});
        end
        d = $urandom;
        apb(1'b1, LO_A, d, 4'h2);
        lo_m = merge(lo_m, d[15:0], 2'b10);
        lo_rd(lo_m);
        apb(1'b1, LD_A, 32'h0, 4'hf);
        ext <= $urandom;
        d = $urandom;
        apb(1'b1, LO_A, d, 4'h3);
        lo_m = d[15:0];
        chk(pin_oe, 32'hffff_0000);
        chk({16'h0, pin_in[15:0]}, {16'h0, ext[15:0]});
        lo_rd(ext[15:0]);
        apb(1'b1, LA_A, 32'hffff, 4'hf);
        lo_rd(16'h0);
        apb(1'b1, LD_A, 32'hffff, 4'hf);
        chk(pin_oe, 32'hffff_0000);
        lo_rd(lo_m);
        apb(1'b1, LA_A, 32'h0, 4'hf);
        chk(pin_out, {up_m, lo_m});
        chk({16'h0, pin_in[15:0]}, {16'h0, lo_m});
        watchdog_rst <= 1'b1;
        @(posedge pclk);
        watchdog_rst <= 1'b0;
        @(posedge pclk);
        chk(pin_out, {up_m, lo_m});
        apb(1'b0, UP_A, 32'h0, 4'h0);
        chk(rd, {ext[15:0], ext[31:16]});
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(pin_out, 32'h0);
        give_verdict();
    end
endmodule : port_d_data_registers_bench
